// *** rtl/cow_pkg.sv ***
// Constants, field layouts and carrier types of the clock-out and wakeup
// timer block.
// Assumes a 100 MHz bus clock and a 32-bit APB register port.
package cow_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CLK_OUT_CTRL = 8'h00;
    localparam logic [7:0] OFS_PART_ID_HIGH = 8'h04;
    localparam logic [7:0] OFS_PART_ID_LOW  = 8'h08;
    localparam logic [7:0] OFS_WAKEUP_CTRL  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CO_PIN_EN_BIT  = 4;
    localparam int WK_FLAG_BIT    = 7;
    localparam int WK_CLEAR_BIT   = 6;
    localparam int WK_CLKSEL_BIT  = 5;
    localparam int WK_INTEN_BIT   = 4;
    localparam int IRQ_TIMEOUT_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CO_DIV_RST    = 3'h0;
    localparam logic [2:0] WK_DELAY_RST  = 3'h0;
    localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int INT_OSC_PERIOD_NS = 1_000_000;
    localparam int INT_TICK_CYC      = INT_OSC_PERIOD_NS / CLK_PERIOD_NS;

    // Arbitrary neutral part number
    localparam logic [11:0] PART_ID_DEFAULT = 12'h5A3;

    typedef struct packed {
        logic       pin_en;
        logic [2:0] div;
    } cow_co_ctrl_type;

    typedef struct packed {
        logic       clk_sel;
        logic       int_en;
        logic [2:0] delay;
    } cow_wk_ctrl_type;

endpackage

// *** rtl/cow_clock_out_wakeup_timer.sv ***
// Clock output divider, read-only part number and periodic wakeup timer,
// reached over APB.
// Assumes ext_clk_i is slow against clk_i; it is synchronised here.
`timescale 1ns/100ps
`default_nettype none

module cow_clock_out_wakeup_timer #(
    parameter int unsigned INT_TICK_CYCLES = cow_pkg::INT_TICK_CYC,
    parameter logic [11:0] PART_ID         = cow_pkg::PART_ID_DEFAULT
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // External wakeup clock
    input  wire logic        ext_clk_i,
    // Clock output port pin
    output logic             clock_out_port_pin_o,
    output logic             clock_out_port_pin_oe_o,
    // Interrupt
    output logic             irq_o
);

    localparam int PS_W = $clog2(INT_TICK_CYCLES + 1);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0]               prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    cow_pkg::cow_co_ctrl_type  co_ctrl_ff;
    cow_pkg::cow_wk_ctrl_type  wk_ctrl_ff;
    logic                      wk_flag_ff;
    logic [7:0]                irq_sts_ff;
    logic [7:0]                irq_mask_ff;
    logic                      irq_ff;
    logic [2:0]                co_cnt_ff;
    logic                      co_pin_ff;
    logic                      co_oe_ff;
    logic [PS_W-1:0]           ps_ff;
    logic                      ext_s1_ff;
    logic                      ext_s2_ff;
    logic                      ext_s3_ff;
    logic [15:0]               wk_cnt_ff;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_w  = psel_i & ~penable_i;
    wire access_w = psel_i & penable_i & pready_ff;
    wire wr_w     = access_w & pwrite_i;
    wire sel_co   = (paddr_i == cow_pkg::OFS_CLK_OUT_CTRL);
    wire sel_idh  = (paddr_i == cow_pkg::OFS_PART_ID_HIGH);
    wire sel_idl  = (paddr_i == cow_pkg::OFS_PART_ID_LOW);
    wire sel_wk   = (paddr_i == cow_pkg::OFS_WAKEUP_CTRL);
    wire sel_ists = (paddr_i == cow_pkg::OFS_IRQ_STATUS);
    wire sel_imsk = (paddr_i == cow_pkg::OFS_IRQ_MASK);
    wire mapped_w = sel_co | sel_idh | sel_idl | sel_wk | sel_ists | sel_imsk;

    wire wr_co   = wr_w & sel_co;
    wire wr_wk   = wr_w & sel_wk;
    wire wr_ists = wr_w & sel_ists;
    wire wr_imsk = wr_w & sel_imsk;

    // Part number writes fall through untouched
    wire [7:0] co_rd   = {3'h0, co_ctrl_ff.pin_en, 1'b0, co_ctrl_ff.div};
    wire [7:0] idh_rd  = {4'h0, PART_ID[11:8]};
    wire [7:0] idl_rd  = PART_ID[7:0];
    // Clear bit and unused positions read zero
    wire [7:0] wk_rd   = {wk_flag_ff, 1'b0, wk_ctrl_ff.clk_sel,
                          wk_ctrl_ff.int_en, 1'b0, wk_ctrl_ff.delay};

    logic [7:0] rd_byte;
    always_comb begin
        if (sel_co) begin
            rd_byte = co_rd;
        end else if (sel_idh) begin
            rd_byte = idh_rd;
        end else if (sel_idl) begin
            rd_byte = idl_rd;
        end else if (sel_wk) begin
            rd_byte = wk_rd;
        end else if (sel_ists) begin
            rd_byte = irq_sts_ff;
        end else if (sel_imsk) begin
            rd_byte = irq_mask_ff;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Data is captured in setup so the access phase needs no wait
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= setup_w ? {24'h00_0000, rd_byte} : prdata_ff;
            pready_ff  <= setup_w;
            pslverr_ff <= setup_w & ~mapped_w;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire cow_pkg::cow_wk_ctrl_type wk_new = {pwdata_i[cow_pkg::WK_CLKSEL_BIT],
                                             pwdata_i[cow_pkg::WK_INTEN_BIT],
                                             pwdata_i[2:0]};
    // Restart only when period or source really changes
    wire cfg_change = wr_wk & ((wk_new.clk_sel != wk_ctrl_ff.clk_sel) |
                               (wk_new.delay != wk_ctrl_ff.delay));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            co_ctrl_ff  <= '{pin_en: 1'b0, div: cow_pkg::CO_DIV_RST};
            wk_ctrl_ff  <= '{clk_sel: 1'b0, int_en: 1'b0,
                             delay: cow_pkg::WK_DELAY_RST};
            irq_mask_ff <= cow_pkg::IRQ_MASK_RST;
        end else begin
            if (wr_co) begin
                co_ctrl_ff <= {pwdata_i[cow_pkg::CO_PIN_EN_BIT],
                               pwdata_i[2:0]};
            end
            if (wr_wk) begin
                wk_ctrl_ff <= wk_new;
            end
            if (wr_imsk) begin
                irq_mask_ff <= pwdata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Clock output divider
    // ------------------------------------------------------------
    wire       co_run   = co_ctrl_ff.pin_en & (co_ctrl_ff.div != 3'h0);
    // Half period is N bus cycles, full period 2N
    wire       co_wrap  = co_run & (co_cnt_ff >= co_ctrl_ff.div - 3'h1);
    wire [2:0] nxt_co_cnt = (!co_run || co_wrap) ? 3'h0 : co_cnt_ff + 3'h1;
    // Off, or on with zero divider, both hold the pin low
    wire       nxt_co_pin = co_run & (co_wrap ? ~co_pin_ff : co_pin_ff);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            co_cnt_ff <= 3'h0;
            co_pin_ff <= 1'b0;
            co_oe_ff  <= 1'b0;
        end else begin
            co_cnt_ff <= nxt_co_cnt;
            co_pin_ff <= nxt_co_pin;
            co_oe_ff  <= co_ctrl_ff.pin_en;
        end
    end

    // ------------------------------------------------------------
    // Wakeup tick sources
    // ------------------------------------------------------------
    // Prescaler never restarts, so the 1 kHz base stays free
    wire int_tick = (ps_ff == PS_W'(INT_TICK_CYCLES - 1));
    wire ext_tick = ext_s2_ff & ~ext_s3_ff;
    wire wk_tick  = wk_ctrl_ff.clk_sel ? ext_tick : int_tick;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ps_ff     <= '0;
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ps_ff     <= int_tick ? '0 : ps_ff + PS_W'(1);
            ext_s1_ff <= ext_clk_i;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // Wakeup period counter
    // ------------------------------------------------------------
    logic [15:0] wk_period;
    always_comb begin
        case ({wk_ctrl_ff.clk_sel, wk_ctrl_ff.delay})
            4'h1:    wk_period = 16'h0008;
            4'h2:    wk_period = 16'h0020;
            4'h3:    wk_period = 16'h0040;
            4'h4:    wk_period = 16'h0080;
            4'h5:    wk_period = 16'h0100;
            4'h6:    wk_period = 16'h0200;
            4'h7:    wk_period = 16'h0400;
            4'h9:    wk_period = 16'h0100;
            4'hA:    wk_period = 16'h0400;
            4'hB:    wk_period = 16'h0800;
            4'hC:    wk_period = 16'h1000;
            4'hD:    wk_period = 16'h2000;
            4'hE:    wk_period = 16'h4000;
            4'hF:    wk_period = 16'h8000;
            default: wk_period = 16'h0000;
        endcase
    end

    wire wk_active  = (wk_ctrl_ff.delay != 3'h0);
    wire wk_last    = (wk_cnt_ff == wk_period - 16'h0001);
    wire wk_timeout = wk_active & wk_tick & wk_last & ~cfg_change;

    logic [15:0] nxt_wk_cnt;
    always_comb begin
        if (cfg_change || !wk_active) begin
            nxt_wk_cnt = 16'h0000;
        end else if (wk_tick) begin
            nxt_wk_cnt = wk_last ? 16'h0000 : wk_cnt_ff + 16'h0001;
        end else begin
            nxt_wk_cnt = wk_cnt_ff;
        end
    end

    // Hardware set beats a same-cycle clear
    wire wk_clear     = wr_wk & pwdata_i[cow_pkg::WK_CLEAR_BIT];
    wire nxt_wk_flag  = wk_timeout | (wk_flag_ff & ~wk_clear);
    wire [7:0] evt_w  = {7'h00, wk_timeout};
    wire [7:0] ists_clr = wr_ists ? pwdata_i[7:0] : 8'h00;
    wire [7:0] nxt_irq_sts = evt_w | (irq_sts_ff & ~ists_clr);
    // Either the flag path or the masked sticky path raises the line
    wire nxt_irq = (nxt_wk_flag & wk_ctrl_ff.int_en) |
                   (|(nxt_irq_sts & irq_mask_ff));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wk_cnt_ff  <= 16'h0000;
            wk_flag_ff <= 1'b0;
            irq_sts_ff <= 8'h00;
            irq_ff     <= 1'b0;
        end else begin
            wk_cnt_ff  <= nxt_wk_cnt;
            wk_flag_ff <= nxt_wk_flag;
            irq_sts_ff <= nxt_irq_sts;
            irq_ff     <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o                = prdata_ff;
    assign pready_o                = pready_ff;
    assign pslverr_o               = pslverr_ff;
    assign clock_out_port_pin_o    = co_pin_ff;
    assign clock_out_port_pin_oe_o = co_oe_ff;
    assign irq_o                   = irq_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    pin_off_low_a: assert property (
        !co_ctrl_ff.pin_en
        |=> !clock_out_port_pin_o && !clock_out_port_pin_oe_o)
        else $error("clock pin active while disabled");

    zero_div_low_a: assert property (
        (co_ctrl_ff.pin_en && co_ctrl_ff.div == 3'h0)[*2]
        |=> !clock_out_port_pin_o && clock_out_port_pin_oe_o)
        else $error("zero divider did not hold pin low");

    div_two_hold_a: assert property (
        (co_run && co_ctrl_ff.div == 3'h2 && $changed(clock_out_port_pin_o)
         && !$changed(co_ctrl_ff))
        ##1 (co_run && co_ctrl_ff.div == 3'h2)
        |-> $stable(clock_out_port_pin_o) ##1 $changed(clock_out_port_pin_o))
        else $error("divide by four half period wrong");

    id_read_a: assert property (
        (setup_w && sel_idh) |=> prdata_o == {28'h000_0000, PART_ID[11:8]})
        else $error("part id high read wrong");

    wk_read_zero_a: assert property (
        (setup_w && sel_wk) |=> prdata_o[6] == 1'b0 && prdata_o[3] == 1'b0)
        else $error("unused wakeup bits read nonzero");

    flag_clear_a: assert property (
        (wk_clear && !wk_timeout) |=> !wk_flag_ff)
        else $error("flag not cleared by write of one");

    flag_set_a: assert property (
        wk_timeout |=> wk_flag_ff && wk_cnt_ff == 16'h0000)
        else $error("timeout did not set flag");

    disabled_quiet_a: assert property (
        (wk_ctrl_ff.delay == 3'h0) |-> !wk_timeout ##1 wk_cnt_ff == 16'h0000)
        else $error("disabled timer still counts");

    cfg_restart_a: assert property (
        cfg_change |=> wk_cnt_ff == 16'h0000)
        else $error("counter not restarted on change");

    irq_level_a: assert property (
        (wk_flag_ff && wk_ctrl_ff.int_en && $stable(wk_flag_ff)
         && $stable(wk_ctrl_ff.int_en)) |-> irq_o)
        else $error("interrupt missing while flag enabled");

    int_base_a: assert property (
        (!wk_ctrl_ff.clk_sel && wk_ctrl_ff.delay == 3'h1 && wk_tick
         && wk_cnt_ff == 16'h0007 && !cfg_change) |-> wk_timeout)
        else $error("eight tick period missed");

endmodule

`default_nettype wire

// *** verif/cow_clock_out_wakeup_timer_tb_top.sv ***
// Self-checking testbench of the clock-out and wakeup timer block.
// Assumes the design package is compiled first; drives APB and ext clock.
`timescale 1ns/100ps
`default_nettype none

module cow_clock_out_wakeup_timer_tb_top;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int          TICK  = 10;
    // Arbitrary neutral part number
    localparam logic [11:0] TB_ID = 12'hA5C;

    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk = 1'b0;
    logic        pin;
    logic        oe;
    logic        irq;
    int          mismatches = 0;
    int          checked = 0;
    logic [31:0] rd;
    logic        err;
    int          n;

    always #5 clk_i = ~clk_i;

    cow_clock_out_wakeup_timer #(
        .INT_TICK_CYCLES (TICK),
        .PART_ID         (TB_ID)
    ) dut_u (
        .clk_i                   (clk_i),
        .reset_n_i               (reset_n_i),
        .psel_i                  (psel),
        .penable_i               (penable),
        .pwrite_i                (pwrite),
        .paddr_i                 (paddr),
        .pwdata_i                (pwdata),
        .prdata_o                (prdata),
        .pready_o                (pready),
        .pslverr_o               (pslverr),
        .ext_clk_i               (ext_clk),
        .clock_out_port_pin_o    (pin),
        .clock_out_port_pin_oe_o (oe),
        .irq_o                   (irq)
    );

    // ------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic int int_ticks(input logic [2:0] c);
        return (c == 3'h1) ? 8 : (c == 3'h7) ? 1024 : (32 << (c - 2));
    endfunction

    function automatic int ext_div(input logic [2:0] c);
        return 256 << ((c == 3'h1) ? 0 : c);
    endfunction

    // Random spacing keeps the synchroniser honest
    task automatic ext_edges(input int cnt);
        repeat (cnt) begin
            @(posedge clk_i);
            ext_clk <= 1'b1;
            repeat ($urandom_range(2, 3)) @(posedge clk_i);
            ext_clk <= 1'b0;
            repeat ($urandom_range(2, 3)) @(posedge clk_i);
        end
    endtask

    // Steps one edge first: the level left by an earlier timeout still
    // shows in the time step of the write that clears it
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask

    task automatic clk_out(input logic [2:0] dv);
        logic prev;
        apb(1'b1, cow_pkg::OFS_CLK_OUT_CTRL, 32'h10 | 32'(dv));
        repeat (4) @(negedge clk_i);
        check(32'(oe), 32'h1);
        if (dv == 3'h0) begin
            repeat (20) begin
                @(negedge clk_i);
                check(32'(pin), 32'h0);
            end
        end else begin
            prev = pin;
            n = 0;
            while (pin === prev && n < 40) begin
                @(negedge clk_i);
                n++;
            end
            repeat (2) begin
                prev = pin;
                n = 0;
                do begin
                    @(negedge clk_i);
                    n++;
                end while (pin === prev && n < 40);
                check(32'(n), 32'(dv));
            end
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h144CF562));
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        check(32'({irq, oe, pin}), 32'h0);
        apb(1'b0, cow_pkg::OFS_CLK_OUT_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, cow_pkg::OFS_IRQ_MASK, 32'h0);
        check(rd, 32'h0);
        // Identification bytes survive random writes
        repeat (2) begin
            apb(1'b0, cow_pkg::OFS_PART_ID_HIGH, 32'h0);
            check(rd, 32'(TB_ID[11:8]));
            apb(1'b0, cow_pkg::OFS_PART_ID_LOW, 32'h0);
            check(rd, 32'(TB_ID[7:0]));
            apb(1'b1, cow_pkg::OFS_PART_ID_HIGH, $urandom());
            apb(1'b1, cow_pkg::OFS_PART_ID_LOW, $urandom());
        end
        apb(1'b1, 8'h18, $urandom());
        check(32'(err), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // Divided clock for every divider code
        for (int d = 0; d < 8; d++) clk_out(3'(d));
        apb(1'b1, cow_pkg::OFS_CLK_OUT_CTRL, 32'h03);
        repeat (4) @(negedge clk_i);
        check(32'({oe, pin}), 32'h0);
        // Internal source, delay codes 1 to 7, restart on each change
        for (int c = 1; c < 8; c++) begin
            apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h50 | 32'(c));
            wait_irq(int_ticks(3'(c)) * TICK + 40);
            check(32'(n >= int_ticks(3'(c)) * TICK - 12
                   && n <= int_ticks(3'(c)) * TICK + 12), 32'h1);
        end
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h97);
        apb(1'b0, cow_pkg::OFS_IRQ_STATUS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, cow_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h07);
        repeat (2) @(negedge clk_i);
        check(32'(irq), 32'h1);
        apb(1'b1, cow_pkg::OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(negedge clk_i);
        check(32'(irq), 32'h0);
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h87);
        apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h07);
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h87);
        apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h47);
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h07);
        apb(1'b1, cow_pkg::OFS_IRQ_MASK, 32'h0);
        // Delay code zero never times out
        apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h50);
        repeat (300) @(negedge clk_i);
        check(32'(irq), 32'h0);
        apb(1'b0, cow_pkg::OFS_WAKEUP_CTRL, 32'h0);
        check(rd, 32'h10);
        // External source: no timeout one edge early, timeout on the last
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, cow_pkg::OFS_WAKEUP_CTRL, 32'h70 | 32'(c));
            ext_edges(ext_div(3'(c)) - 1);
            repeat (8) @(negedge clk_i);
            check(32'(irq), 32'h0);
            ext_edges(1);
            wait_irq(12);
            check(32'(irq), 32'h1);
        end
        final_report();
    end

    // ------------------------------------------------------------
    // Watchdog: tests need about 41k cycles
    // ------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge clk_i);
        mismatches++;
        final_report();
    end

endmodule

`default_nettype wire
